// [logic/fosp_pkg.sv]
package fosp_pkg;
   // software register byte offsets
   localparam logic [7:0] FOSP_CTRL_OFS     = 8'h00;
   localparam logic [7:0] FOSP_ADDR_OFS     = 8'h04;
   localparam logic [7:0] FOSP_STATUS_OFS   = 8'h08;
   localparam logic [7:0] FOSP_IRQ_STAT_OFS = 8'h0C;
   localparam logic [7:0] FOSP_IRQ_MASK_OFS = 8'h10;
   // control register fields
   localparam int FOSP_CTRL_START = 0;
   localparam int FOSP_CTRL_KEEP  = 1;
   // status register fields
   localparam int FOSP_ST_BUSY    = 0;
   localparam int FOSP_ST_DONE    = 1;
   localparam int FOSP_ST_PASS    = 2;
   localparam int FOSP_ST_FAIL    = 3;
   localparam int FOSP_ST_LEFT    = 4;
   localparam int FOSP_ST_TMO     = 5;
   localparam int FOSP_ST_ETOG    = 6;
   localparam int FOSP_ST_ESTART  = 7;
   localparam int FOSP_ST_POLL    = 8;
   localparam int FOSP_ST_BYTE_LO = 16;
   // interrupt event bits
   localparam int FOSP_IRQ_W    = 3;
   localparam int FOSP_IRQ_PASS = 0;
   localparam int FOSP_IRQ_FAIL = 1;
   localparam int FOSP_IRQ_LEFT = 2;
   localparam logic [FOSP_IRQ_W-1:0] FOSP_IRQ_RST = 3'h0;
   // reset values
   localparam logic [31:0] FOSP_ZERO32 = 32'h0000_0000;
   // timing: clock rate and pin timings
   localparam int FOSP_CLK_MHZ    = 10;
   localparam int FOSP_RD_NS      = 70;
   localparam int FOSP_WE_NS      = 100;
   localparam int FOSP_RD_CYC_RAW = (FOSP_RD_NS * FOSP_CLK_MHZ + 999) / 1000;
   localparam int FOSP_WE_CYC_RAW = (FOSP_WE_NS * FOSP_CLK_MHZ + 999) / 1000;
   localparam int FOSP_RD_CYC     = (FOSP_RD_CYC_RAW < 1) ? 1 : FOSP_RD_CYC_RAW;
   localparam int FOSP_WE_CYC     = (FOSP_WE_CYC_RAW < 1) ? 1 : FOSP_WE_CYC_RAW;
   localparam logic [1:0] FOSP_PAIR_DONE = 2'h2;
   // low status byte of the flash data bus
   typedef struct packed {
      logic poll_bit;
      logic toggle_bit_one;
      logic timeout_bit;
      logic rsv4;
      logic erase_started_bit;
      logic erase_toggle_bit_two;
      logic rsv1;
      logic rsv0;
   } fosp_status_t;
   // flash control strobes, all active low
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
   } fosp_strobe_t;
   localparam fosp_strobe_t FOSP_STROBE_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
   // sequencer states
   typedef enum logic [5:0] {
      FOSP_IDLE = 6'b000001,
      FOSP_RD   = 6'b000010,
      FOSP_GAP  = 6'b000100,
      FOSP_EVAL = 6'b001000,
      FOSP_WR   = 6'b010000,
      FOSP_WGAP = 6'b100000
   } fosp_state_t;
endpackage

// [logic/fosp_poll_ctrl.sv]
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module fosp_poll_ctrl #(
   parameter int          ADDR_W    = 19,
   parameter int          DATA_W    = 16,
   parameter logic [15:0] RESET_CMD = 16'h00F0
) (
   // apb clock and reset
   input  wire  logic                     pclk,
   input  wire  logic                     presetn,
   // apb slave
   input  wire  logic                     psel,
   input  wire  logic                     penable,
   input  wire  logic                     pwrite,
   input  wire  logic [7:0]               paddr,
   input  wire  logic [31:0]              pwdata,
   output var   logic [31:0]              prdata,
   output logic                           pready,
   output logic                           pslverr,
   // interrupt
   output logic                           irq,
   // flash pins
   output var   fosp_pkg::fosp_strobe_t   flash_strobe,
   output var   logic [ADDR_W-1:0]        flash_addr,
   input  wire  logic [DATA_W-1:0]        flash_dq_in,
   output var   logic [DATA_W-1:0]        flash_dq_out,
   output var   logic                     flash_dq_oe_n
);
   import fosp_pkg::*;

   // refuse widths the logic cannot serve
   generate
      if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 8 || DATA_W > 16)
      begin : g_bad
         $error("fosp_poll_ctrl: unsupported ADDR_W or DATA_W");
      end
   endgenerate

   fosp_state_t              st_r;
   logic [7:0]               cnt_r;
   logic [1:0]               reads_r;
   logic                     recheck_r;
   fosp_status_t             first_r;
   fosp_status_t             second_r;
   logic                     keep_r;
   logic [ADDR_W-1:0]        addr_r;
   logic                     done_r;
   logic                     pass_r;
   logic                     fail_r;
   logic                     left_r;
   logic                     tmo_r;
   logic                     etog_r;
   logic [FOSP_IRQ_W-1:0]    irq_stat_r;
   logic [FOSP_IRQ_W-1:0]    irq_mask_r;
   logic [FOSP_IRQ_W-1:0]    irq_set;
   logic                     wr_acc;
   logic                     rd_acc;
   logic                     mapped;
   logic                     start_req;
   logic                     toggled;
   logic                     cnt_end;
   fosp_status_t             cur_byte;

   // apb access decode, zero wait states
   assign pready  = 1'b1;
   assign mapped  = (paddr == FOSP_CTRL_OFS) || (paddr == FOSP_ADDR_OFS)
                 || (paddr == FOSP_STATUS_OFS) || (paddr == FOSP_IRQ_STAT_OFS)
                 || (paddr == FOSP_IRQ_MASK_OFS);
   assign pslverr = psel && penable && !mapped;
   assign wr_acc  = psel && penable && pwrite && mapped;
   assign rd_acc  = psel && penable && !pwrite && mapped;
   assign start_req = wr_acc && (paddr == FOSP_CTRL_OFS) && pwdata[FOSP_CTRL_START];

   // sequencer helpers
   assign cur_byte = fosp_status_t'(flash_dq_in[7:0]);
   assign toggled  = first_r.toggle_bit_one != second_r.toggle_bit_one;
   assign cnt_end  = (cnt_r == 8'h00);

   // software-written configuration
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         keep_r     <= 1'b0;
         addr_r     <= '0;
         irq_mask_r <= FOSP_IRQ_RST;
      end
      else if (wr_acc)
      begin
         unique case (paddr)
            FOSP_CTRL_OFS:     keep_r     <= pwdata[FOSP_CTRL_KEEP];
            FOSP_ADDR_OFS:     addr_r     <= pwdata[ADDR_W-1:0];
            FOSP_IRQ_MASK_OFS: irq_mask_r <= pwdata[FOSP_IRQ_W-1:0];
            default:           keep_r     <= keep_r;
         endcase
      end
   end

   // read data registered during the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= FOSP_ZERO32;
      else if (psel && !penable && !pwrite)
      begin
         prdata <= FOSP_ZERO32;
         unique case (paddr)
            FOSP_CTRL_OFS:     prdata[FOSP_CTRL_KEEP] <= keep_r;
            FOSP_ADDR_OFS:     prdata[ADDR_W-1:0] <= addr_r;
            FOSP_STATUS_OFS:
            begin
               prdata[FOSP_ST_BUSY]   <= (st_r != FOSP_IDLE);
               prdata[FOSP_ST_DONE]   <= done_r;
               prdata[FOSP_ST_PASS]   <= pass_r;
               prdata[FOSP_ST_FAIL]   <= fail_r;
               prdata[FOSP_ST_LEFT]   <= left_r;
               prdata[FOSP_ST_TMO]    <= tmo_r;
               prdata[FOSP_ST_ETOG]   <= etog_r;
               prdata[FOSP_ST_ESTART] <= second_r.erase_started_bit;
               prdata[FOSP_ST_POLL]   <= second_r.poll_bit;
               prdata[FOSP_ST_BYTE_LO +: 8] <= second_r;
            end
            FOSP_IRQ_STAT_OFS: prdata[FOSP_IRQ_W-1:0] <= irq_stat_r;
            FOSP_IRQ_MASK_OFS: prdata[FOSP_IRQ_W-1:0] <= irq_mask_r;
            default:           prdata <= FOSP_ZERO32;
         endcase
      end
   end

   // sticky interrupt status, read clears, a new event wins
   always_comb
   begin
      irq_set = '0;
      if (st_r == FOSP_EVAL && !toggled)
         irq_set[FOSP_IRQ_PASS] = 1'b1;
      if (st_r == FOSP_WGAP && cnt_end)
         irq_set[FOSP_IRQ_FAIL] = 1'b1;
      if (st_r == FOSP_EVAL && toggled && !recheck_r && !second_r.timeout_bit && !keep_r)
         irq_set[FOSP_IRQ_LEFT] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat_r <= FOSP_IRQ_RST;
      else if (rd_acc && paddr == FOSP_IRQ_STAT_OFS)
         irq_stat_r <= (irq_stat_r & ~prdata[FOSP_IRQ_W-1:0]) | irq_set; // keep unreported events
      else
         irq_stat_r <= irq_stat_r | irq_set;
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   // toggle-bit polling sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r      <= FOSP_IDLE;
         cnt_r     <= 8'h00;
         reads_r   <= 2'h0;
         recheck_r <= 1'b0;
         first_r   <= '0;
         second_r  <= '0;
      end
      else
      begin
         unique case (st_r)
            FOSP_IDLE:
            begin
               if (start_req)
               begin
                  // every start begins at the first step
                  st_r      <= FOSP_RD;
                  cnt_r     <= 8'(FOSP_RD_CYC - 1);
                  reads_r   <= 2'h0;
                  recheck_r <= 1'b0;
               end
            end
            FOSP_RD:
            begin
               if (cnt_end)
               begin
                  // capture the pair of consecutive reads
                  if (reads_r == 2'h0)
                     first_r <= cur_byte;
                  else
                     second_r <= cur_byte;
                  reads_r <= reads_r + 2'h1;
                  st_r    <= FOSP_GAP;
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            end
            FOSP_GAP:
            begin
               if (reads_r == FOSP_PAIR_DONE)
                  st_r <= FOSP_EVAL;
               else
               begin
                  st_r  <= FOSP_RD;
                  cnt_r <= 8'(FOSP_RD_CYC - 1);
               end
            end
            FOSP_EVAL:
            begin
               reads_r <= 2'h0;
               if (!toggled)
                  st_r <= FOSP_IDLE;
               else if (recheck_r)
               begin
                  st_r  <= FOSP_WR;
                  cnt_r <= 8'(FOSP_WE_CYC - 1);
               end
               else if (second_r.timeout_bit)
               begin
                  st_r      <= FOSP_RD;
                  cnt_r     <= 8'(FOSP_RD_CYC - 1);
                  recheck_r <= 1'b1;
               end
               else if (keep_r)
               begin
                  st_r  <= FOSP_RD;
                  cnt_r <= 8'(FOSP_RD_CYC - 1);
               end
               else
                  st_r <= FOSP_IDLE;
            end
            FOSP_WR:
            begin
               if (cnt_end)
               begin
                  st_r  <= FOSP_WGAP;
                  cnt_r <= 8'(FOSP_WE_CYC - 1);
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            end
            FOSP_WGAP:
            begin
               if (cnt_end)
                  st_r <= FOSP_IDLE;
               else
                  cnt_r <= cnt_r - 8'h01;
            end
         endcase
      end
   end

   // outcome flags, all but etog_r cleared by each new start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_r <= 1'b0;
         pass_r <= 1'b0;
         fail_r <= 1'b0;
         left_r <= 1'b0;
         tmo_r  <= 1'b0;
         etog_r <= 1'b0;
      end
      else if (st_r == FOSP_IDLE && start_req)
      begin
         done_r <= 1'b0;
         pass_r <= 1'b0;
         fail_r <= 1'b0;
         left_r <= 1'b0;
         tmo_r  <= 1'b0;
      end
      else if (st_r == FOSP_EVAL)
      begin
         // bit 2 change marks the addressed sector as being erased
         etog_r <= first_r.erase_toggle_bit_two ^ second_r.erase_toggle_bit_two;
         tmo_r  <= tmo_r | second_r.timeout_bit;
         if (!toggled)
         begin
            done_r <= 1'b1;
            pass_r <= 1'b1;
         end
         else if (!recheck_r && !second_r.timeout_bit && !keep_r)
         begin
            done_r <= 1'b1;
            left_r <= 1'b1;
         end
      end
      else if (st_r == FOSP_WGAP && cnt_end)
      begin
         done_r <= 1'b1;
         fail_r <= 1'b1;
      end
   end

   // flash pin drive
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flash_strobe  <= FOSP_STROBE_IDLE;
         flash_addr    <= '0;
         flash_dq_out  <= '0;
         flash_dq_oe_n <= 1'b1;
      end
      else
      begin
         flash_addr    <= addr_r;
         flash_dq_out  <= RESET_CMD[DATA_W-1:0];
         flash_strobe  <= FOSP_STROBE_IDLE;
         flash_dq_oe_n <= 1'b1;
         if ((st_r == FOSP_IDLE && start_req) || (st_r == FOSP_GAP && reads_r != FOSP_PAIR_DONE)
             || (st_r == FOSP_EVAL && toggled && (recheck_r ? 1'b0
                 : (second_r.timeout_bit || keep_r))) || (st_r == FOSP_RD && !cnt_end))
         begin
            flash_strobe.ce_n <= 1'b0;
            flash_strobe.oe_n <= 1'b0;
         end
         else if ((st_r == FOSP_EVAL && toggled && recheck_r) || (st_r == FOSP_WR && !cnt_end))
         begin
            // reset command write returns the device to array reads
            flash_strobe.ce_n <= 1'b0;
            flash_strobe.we_n <= 1'b0;
            flash_dq_oe_n     <= 1'b0;
         end
      end
   end

   // checks on the polling procedure
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence read_pair_s;
      (st_r == FOSP_GAP) && (reads_r == FOSP_PAIR_DONE) ##1 (st_r == FOSP_EVAL);
   endsequence

   sequence reset_write_s;
      (st_r == FOSP_WR) && !flash_strobe.we_n && !flash_dq_oe_n ##1 flash_dq_out[7:0] == RESET_CMD[7:0];
   endsequence

   pair_before_eval_a: assert property ((st_r == FOSP_EVAL) |-> $past(st_r) == FOSP_GAP && reads_r == FOSP_PAIR_DONE) else $error("eval without two reads");
   stable_pass_a: assert property (read_pair_s ##0 !toggled |=> done_r && pass_r && st_r == FOSP_IDLE) else $error("steady toggle not reported as pass");
   timeout_recheck_a: assert property ((st_r == FOSP_EVAL) && toggled && !recheck_r && second_r.timeout_bit |=> recheck_r && st_r == FOSP_RD && !flash_strobe.oe_n) else $error("timeout seen without recheck");
   fail_reset_a: assert property ((st_r == FOSP_EVAL) && toggled && recheck_r |=> reset_write_s ##[1:20] fail_r && done_r) else $error("failure without reset command");
   restart_poll_a: assert property ((st_r == FOSP_EVAL) && toggled && !recheck_r && !second_r.timeout_bit |=> reads_r == 2'h0 && !recheck_r && (keep_r ? st_r == FOSP_RD : left_r)) else $error("poll does not restart from first step");
   status_addr_a: assert property (!flash_strobe.oe_n |-> flash_addr == $past(addr_r)) else $error("status read outside addressed sector");
   erase_ident_a: assert property ((st_r == FOSP_EVAL) |=> etog_r == ($past(first_r.erase_toggle_bit_two) ^ $past(second_r.erase_toggle_bit_two))) else $error("bit 2 change not recorded");
endmodule
`default_nettype wire

// [dv/fosp_flash_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fosp_flash_model (
   // host pins
   input  wire fosp_pkg::fosp_strobe_t strobe,
   input  wire logic [15:0]            dq_host,
   input  wire logic                   dq_oe_n,
   // scenario controls
   input  wire logic                   arm,
   input  var  int                     busy_reads,
   input  var  int                     tmo_reads,
   input  wire logic                   erasing,
   input  wire logic [7:0]             wr_data,
   // device side
   output logic [15:0]                 dq,
   output logic                        reset_seen
);
   import fosp_pkg::*;
   int          nreads;
   logic        tog1;
   logic        tog2;
   logic        busy;
   logic [15:0] cur;
   logic [15:0] last;
   // operation runs until the scripted read count or a reset command
   assign busy = (nreads < busy_reads) && !reset_seen;
   // status while busy, array data once finished
   assign cur = busy ? {8'h00, erasing ? 1'b0 : ~wr_data[7],
                        tog1, nreads >= tmo_reads, 1'b0, erasing,
                        erasing & tog2, 2'b00}
                     : (erasing ? 16'hFFFF : {8'h00, wr_data});
   // bus shows the word only while read, a changed value otherwise
   assign dq = (!strobe.ce_n && !strobe.oe_n) ? cur : ~last;
   // each finished read flips both toggle bits
   always @(posedge strobe.oe_n or posedge arm)
   begin
      last = arm ? 16'h0000 : cur;
      nreads = arm ? 0 : nreads + 1;
      tog1 = arm ? 1'b0 : ~tog1;
      tog2 = arm ? 1'b0 : ~tog2;
   end
   // reset command ends the operation and returns to array reads
   always @(negedge strobe.we_n or posedge arm)
      reset_seen <= arm ? 1'b0 : (!strobe.ce_n && !dq_oe_n && dq_host[7:0] == 8'hF0);
endmodule
`default_nettype wire

// [dv/flash_operation_status_poll_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_operation_status_poll_tb;
   import fosp_pkg::*;
   logic         pclk = 1'b0;
   logic         presetn;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         irq;
   fosp_strobe_t flash_strobe;
   logic [18:0]  flash_addr;
   logic [15:0]  flash_dq_in;
   logic [15:0]  flash_dq_out;
   logic         flash_dq_oe_n;
   logic         arm = 1'b0;
   int           busy_reads = 0;
   int           tmo_reads = 0;
   logic         erasing = 1'b0;
   logic         reset_seen;
   logic         mask_on = 1'b0;
   logic [31:0]  rdat;
   logic [31:0]  st;
   logic         err;
   int           n_errors = 0;
   int           samples_checked = 0;
   // 10 MHz clock
   always #50 pclk = ~pclk;
   fosp_poll_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .flash_strobe(flash_strobe), .flash_addr(flash_addr),
      .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n));
   fosp_flash_model flash (.strobe(flash_strobe), .dq_host(flash_dq_out),
      .dq_oe_n(flash_dq_oe_n), .arm(arm), .busy_reads(busy_reads), .tmo_reads(tmo_reads),
      .erasing(erasing), .wr_data(8'h5A), .dq(flash_dq_in), .reset_seen(reset_seen));
   // counts and verdict, then stop
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // one apb transfer: setup, access until pready, release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16)
      begin
         n++;
         @(posedge pclk);
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16)
      begin
         n_errors++;
         conclude();
      end
   endtask
   // one status check against a scripted device, then result and events
   task automatic op(input logic keep, input int busy, input int tmo, input logic ers,
                     input logic [4:0] res, input logic [7:0] lo, input logic [2:0] evt);
      int n;
      n = 0;
      @(posedge pclk);
      busy_reads <= busy;
      tmo_reads <= tmo;
      erasing <= ers;
      arm <= 1'b1;
      @(posedge pclk);
      arm <= 1'b0;
      apb(1'b1, FOSP_ADDR_OFS, 32'h0001_2345);
      apb(1'b1, FOSP_CTRL_OFS, {30'h0, keep, 1'b1});
      chk({13'h0000, flash_addr}, 32'h0001_2345, "flash address");
      do
      begin
         apb(1'b0, FOSP_STATUS_OFS, FOSP_ZERO32);
         n++;
      end
      while (rdat[FOSP_ST_DONE] !== 1'b1 && n < 40);
      if (rdat[FOSP_ST_DONE] !== 1'b1)
      begin
         n_errors++;
         conclude();
      end
      st = rdat;
      chk({27'h0, st[4:0]}, {27'h0, res}, "result flags");
      chk({24'h0, st[23:16]}, {24'h0, lo}, "last status byte");
      chk({31'h0, reset_seen}, {31'h0, res == 5'h0A}, "reset command");
      chk({31'h0, irq}, {31'h0, mask_on}, "interrupt level");
      apb(1'b0, FOSP_IRQ_STAT_OFS, FOSP_ZERO32);
      chk({29'h0, rdat[2:0]}, {29'h0, evt}, "interrupt events");
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "interrupt cleared");
   endtask
   // defaults, read-only status, unmapped address, masked interrupt
   task automatic t_regs();
      apb(1'b0, FOSP_STATUS_OFS, FOSP_ZERO32);
      chk(rdat, FOSP_ZERO32, "status after reset");
      apb(1'b1, FOSP_STATUS_OFS, 32'hFFFF_FFFF);
      apb(1'b0, FOSP_STATUS_OFS, FOSP_ZERO32);
      chk(rdat, FOSP_ZERO32, "status is read only");
      apb(1'b1, 8'h40, 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h1, "unmapped write error");
      apb(1'b0, 8'h40, FOSP_ZERO32);
      chk(rdat, FOSP_ZERO32, "unmapped read data");
      chk({29'h0, flash_strobe}, 32'h7, "idle strobes");
      op(1'b0, 0, 1000, 1'b0, 5'h06, 8'h5A, 3'h1);
      $display("test regs done");
   endtask
   // program finished at once, then one that toggles for one pair
   task automatic t_program();
      op(1'b0, 0, 1000, 1'b0, 5'h06, 8'h5A, 3'h1);
      op(1'b1, 2, 1000, 1'b0, 5'h06, 8'h5A, 3'h1);
      chk({31'h0, st[FOSP_ST_TMO]}, 32'h0, "no timeout seen");
      $display("test program done");
   endtask
   // timeout bit high: toggle stops in time, or keeps on and fails
   task automatic t_timeout();
      op(1'b0, 2, 1, 1'b0, 5'h06, 8'h5A, 3'h1);
      chk({31'h0, st[FOSP_ST_TMO]}, 32'h1, "timeout seen");
      op(1'b0, 100, 1, 1'b0, 5'h0A, 8'hE0, 3'h2);
      $display("test timeout done");
   endtask
   // still toggling without timeout: left running
   task automatic t_left();
      op(1'b0, 100, 1000, 1'b0, 5'h12, 8'hC0, 3'h4);
      chk({31'h0, st[FOSP_ST_POLL]}, 32'h1, "poll bit inverted");
      $display("test left done");
   endtask
   // erase: bit two toggles, erase-started high, poll bit low
   task automatic t_erase();
      op(1'b0, 100, 1000, 1'b1, 5'h12, 8'h4C, 3'h4);
      chk({29'h0, st[FOSP_ST_POLL], st[FOSP_ST_ESTART], st[FOSP_ST_ETOG]}, 32'h3, "erase");
      op(1'b0, 100, 1, 1'b1, 5'h0A, 8'h6C, 3'h2);
      chk({31'h0, st[FOSP_ST_ETOG]}, 32'h1, "erase error sector");
      op(1'b0, 0, 1000, 1'b1, 5'h06, 8'hFF, 3'h1);
      $display("test erase done");
   endtask
   // reset, then the scenarios
   initial
   begin
      // a real falling edge so the asynchronous reset takes hold
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      apb(1'b1, FOSP_IRQ_MASK_OFS, 32'h0000_0007);
      mask_on = 1'b1;
      t_program();
      t_timeout();
      t_left();
      t_erase();
      conclude();
   end
endmodule
`default_nettype wire
